// ---- hw/slc_regs.sv ----
/*
 * APB register bank for the serializer link control: spread modulation
 * calibration and link/channel control, with strap capture, reverse
 * channel blackout and modulation recalibration pulses.
 * Assumes an APB master on pclk, a lock level from same-clock logic and
 * asynchronous strap pins.
 */
// The APB register port is this design's own decision.
module slc_regs
    import slc_pkg::*;
#(
    parameter int unsigned HOLDOFF_CYCLES = HOLDOFF_CYC,
    parameter int unsigned MS_CYCLES      = MS_CYC
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire slc_apb_req_t apb_i,
    output slc_apb_rsp_t      apb_o,
    input  wire logic         auto_start_pin,
    input  wire logic         control_direction_pin,
    input  wire logic         pll_locked,
    output slc_ctl_t          ctl_o
);

    localparam int unsigned HOLD_W = $clog2(HOLDOFF_CYCLES + 1);
    localparam int unsigned MS_W   = $clog2(MS_CYCLES + 1);

    if (HOLDOFF_CYCLES < 1 || MS_CYCLES < 2) begin : g_param_check
        $error("slc_regs: timing parameters too small");
    end

    typedef enum logic [1:0] {
        ST_STRAP = 2'b01,
        ST_RUN   = 2'b10
    } slc_fsm_t;

    typedef struct packed {
        slc_fsm_t     fsm;
        logic [2:0]   strap_cnt;
        slc_modcal_t  modcal;
        slc_linkctl_t linkctl;
        logic [31:0]  prdata;
        logic         pslverr;
        logic [MS_W-1:0] ms_cnt;
        logic         ms_tick;
        logic         lock_q;
        slc_ctl_t     ctl;
    } slc_state_t;

    localparam slc_state_t STATE_RST = '{
        fsm:       ST_STRAP,
        strap_cnt: 3'h0,
        modcal:    MODCAL_RST,
        linkctl:   LINKCTL_RST,
        prdata:    32'h0000_0000,
        pslverr:   1'b0,
        ms_cnt:    '0,
        ms_tick:   1'b0,
        lock_q:    1'b0,
        ctl:       '0
    };

    slc_state_t s_q;
    slc_state_t s_d;

    logic [1:0]         straps;
    logic               holdoff_load;
    logic               holdoff_busy;
    logic               recal_load;
    logic               recal_clear;
    logic [RECAL_W-1:0] recal_val;
    logic               recal_busy;
    logic               recal_done;

    // Strap pins come from outside the clock domain
    slc_pin_sync #(
        .W (2)
    ) u_strap_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     ({control_direction_pin, auto_start_pin}),
        .level   (straps)
    );

    // Reverse channel blackout counter, one count per clock
    slc_timer #(
        .W (HOLD_W)
    ) u_holdoff (
        .pclk     (pclk),
        .presetn  (presetn),
        .clear    (1'b0),
        .load     (holdoff_load),
        .load_val (HOLD_W'(HOLDOFF_CYCLES)),
        .tick     (1'b1),
        .busy     (holdoff_busy),
        .done     ()
    );

    // Recalibration period counter, one count per millisecond
    slc_timer #(
        .W (RECAL_W)
    ) u_recal (
        .pclk     (pclk),
        .presetn  (presetn),
        .clear    (recal_clear),
        .load     (recal_load),
        .load_val (recal_val),
        .tick     (s_q.ms_tick),
        .busy     (recal_busy),
        .done     (recal_done)
    );

    function automatic logic [RECAL_W-1:0] recal_period(input logic [1:0] code);
        logic [RECAL_W-1:0] p;
        p = '0;
        unique case (code)
            RECAL_2MS:   p = RECAL_W'(RECAL_2MS_MS);
            RECAL_16MS:  p = RECAL_W'(RECAL_16MS_MS);
            RECAL_256MS: p = RECAL_W'(RECAL_256MS_MS);
            RECAL_ONCE:  p = '0;
        endcase
        return p;
    endfunction

    logic        setup_ph;
    logic        access_ph;
    logic        hit_modcal;
    logic        hit_linkctl;
    logic        wr_en;
    logic        lock_rise;
    logic [7:0]  wbyte;

    always_comb begin
        s_d          = s_q;
        holdoff_load = 1'b0;
        recal_load   = 1'b0;
        recal_clear  = 1'b0;
        recal_val    = recal_period(s_q.modcal.interval);

        setup_ph    = apb_i.psel && !apb_i.penable;
        access_ph   = apb_i.psel && apb_i.penable;
        hit_modcal  = (apb_i.paddr[ADDR_W-1:2] == MODCAL_IDX);
        hit_linkctl = (apb_i.paddr[ADDR_W-1:2] == LINKCTL_IDX);
        wbyte       = apb_i.pwdata[7:0];
        wr_en       = access_ph && apb_i.pwrite && apb_i.pstrb[0]
                      && (s_q.fsm == ST_RUN);
        lock_rise   = pll_locked && !s_q.lock_q;

        unique case (s_q.fsm)
            ST_STRAP: begin
                // Wait for the synchroniser before trusting the pins
                if (s_q.strap_cnt == STRAP_SETTLE) begin
                    s_d.fsm = ST_RUN;
                    s_d.linkctl.serial_link_enable = !straps[0];
                    s_d.linkctl.sleep = straps[0] && !straps[1];
                end else begin
                    s_d.strap_cnt = s_q.strap_cnt + 3'h1;
                end
            end
            ST_RUN: begin
                if (wr_en && hit_modcal) begin
                    s_d.modcal = wbyte;
                end
                if (wr_en && hit_linkctl) begin
                    s_d.linkctl = wbyte;
                end
            end
            default: begin
                s_d.fsm = ST_STRAP;
            end
        endcase

        // Reload while stretched by the strap wait too, so the first read sees captured values
        if (setup_ph || (apb_i.psel && s_q.fsm != ST_RUN)) begin
            s_d.prdata  = 32'h0000_0000;
            s_d.pslverr = !(hit_modcal || hit_linkctl);
            if (hit_modcal) begin
                s_d.prdata[7:0] = s_d.modcal;
            end
            if (hit_linkctl) begin
                s_d.prdata[7:0] = s_d.linkctl;
            end
        end

        // Any start or stop of the link restarts the blackout
        holdoff_load = (s_d.linkctl.serial_link_enable
                        != s_q.linkctl.serial_link_enable);

        // Millisecond enable runs only while locked
        s_d.ms_tick = 1'b0;
        if (pll_locked) begin
            if (s_q.ms_cnt == MS_W'(MS_CYCLES - 1)) begin
                s_d.ms_cnt  = '0;
                s_d.ms_tick = 1'b1;
            end else begin
                s_d.ms_cnt = s_q.ms_cnt + MS_W'(1);
            end
        end else begin
            s_d.ms_cnt = '0;
        end
        s_d.lock_q = pll_locked;

        // Calibrate at lock, then repeat at the chosen period
        recal_val = recal_period(s_d.modcal.interval);
        // Once-only mode drops a pending period so no late pulse follows
        if (!pll_locked || s_d.modcal.interval == RECAL_ONCE) begin
            recal_clear = 1'b1;
        end else begin
            // A new interval takes effect at once rather than after the old period
            recal_load = lock_rise || recal_done
                         || (s_d.modcal.interval != s_q.modcal.interval);
        end

        s_d.ctl.serial_link_enable     = s_d.linkctl.serial_link_enable;
        s_d.ctl.config_link_enable     = s_d.linkctl.config_link_enable;
        s_d.ctl.prbs_test_enable       = s_d.linkctl.prbs_test_enable;
        s_d.ctl.sleep                  = s_d.linkctl.sleep;
        s_d.ctl.periph_i2c_enable      = (s_d.linkctl.peripheral_if_type
                                          == IFTYPE_I2C);
        s_d.ctl.periph_uart_enable     = (s_d.linkctl.peripheral_if_type
                                          == IFTYPE_UART);
        // Gate on the load too, so no cycle slips through before busy rises
        s_d.ctl.reverse_channel_enable = s_d.linkctl.reverse_channel_enable
                                         && !holdoff_busy
                                         && !holdoff_load;
        s_d.ctl.forward_channel_enable = s_d.linkctl.forward_channel_enable;
        s_d.ctl.sawtooth_autocal       = (s_d.modcal.divider == 6'h00);
        s_d.ctl.sawtooth_divider       = s_d.modcal.divider;
        s_d.ctl.modulation_recal       = pll_locked && (lock_rise || (recal_done && !recal_clear));
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= STATE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // Ready is held low while straps settle, stretching the first access
    assign apb_o.pready  = (s_q.fsm == ST_RUN);
    assign apb_o.prdata  = s_q.prdata;
    assign apb_o.pslverr = s_q.pslverr && apb_i.psel && apb_i.penable;
    assign ctl_o         = s_q.ctl;

endmodule // slc_regs

// ---- hw/slc_pkg.sv ----
/*
 * Shared constants and carrier types for the serializer link control
 * register bank: register indices, field positions, reset values,
 * interval codes and timing counts.
 * Assumes a single 50 MHz APB clock.
 */
package slc_pkg;

    // Clock
    localparam int unsigned CLK_NS          = 20;

    // Register indices; byte address is four times the index
    localparam logic [9:0]  MODCAL_IDX      = 10'h003;
    localparam logic [9:0]  LINKCTL_IDX     = 10'h004;
    localparam int unsigned ADDR_W          = 12;

    // Field positions, modulation calibration register
    localparam int unsigned MC_INTERVAL_LSB = 6;
    localparam int unsigned MC_DIVIDER_LSB  = 0;

    // Field positions, link and channel control register
    localparam int unsigned LC_SERIAL_BIT   = 7;
    localparam int unsigned LC_CONFIG_BIT   = 6;
    localparam int unsigned LC_PRBS_BIT     = 5;
    localparam int unsigned LC_SLEEP_BIT    = 4;
    localparam int unsigned LC_IFTYPE_LSB   = 2;
    localparam int unsigned LC_REV_BIT      = 1;
    localparam int unsigned LC_FWD_BIT      = 0;

    // Reset values before the strap pins are applied
    localparam logic [7:0]  MODCAL_RST      = 8'h00;
    localparam logic [7:0]  LINKCTL_RST     = 8'h03;

    // Peripheral interface type codes; 10 and 11 disable it
    localparam logic [1:0]  IFTYPE_I2C      = 2'h0;
    localparam logic [1:0]  IFTYPE_UART     = 2'h1;

    // Recalibration interval codes and their periods in ms
    localparam logic [1:0]  RECAL_ONCE      = 2'h0;
    localparam logic [1:0]  RECAL_2MS       = 2'h1;
    localparam logic [1:0]  RECAL_16MS      = 2'h2;
    localparam logic [1:0]  RECAL_256MS     = 2'h3;
    localparam int unsigned RECAL_2MS_MS    = 2;
    localparam int unsigned RECAL_16MS_MS   = 16;
    localparam int unsigned RECAL_256MS_MS  = 256;
    localparam int unsigned RECAL_W         = 9;

    // Reverse channel blackout after a serial link start or stop
    localparam int unsigned HOLDOFF_US      = 350;
    localparam int unsigned HOLDOFF_CYC     = (HOLDOFF_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int unsigned MS_CYC          = 1000000 / CLK_NS;

    // Cycles after reset release before the straps are trusted
    localparam logic [2:0]  STRAP_SETTLE    = 3'h5;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0]       pwdata;
        logic [3:0]        pstrb;
    } slc_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } slc_apb_rsp_t;

    typedef struct packed {
        logic [1:0] interval;
        logic [5:0] divider;
    } slc_modcal_t;

    typedef struct packed {
        logic       serial_link_enable;
        logic       config_link_enable;
        logic       prbs_test_enable;
        logic       sleep;
        logic [1:0] peripheral_if_type;
        logic       reverse_channel_enable;
        logic       forward_channel_enable;
    } slc_linkctl_t;

    typedef struct packed {
        logic       serial_link_enable;
        logic       config_link_enable;
        logic       prbs_test_enable;
        logic       sleep;
        logic       periph_i2c_enable;
        logic       periph_uart_enable;
        logic       reverse_channel_enable;
        logic       forward_channel_enable;
        logic       sawtooth_autocal;
        logic [5:0] sawtooth_divider;
        logic       modulation_recal;
    } slc_ctl_t;

endpackage

// ---- hw/slc_pin_sync.sv ----
/*
 * Three-stage synchroniser for asynchronous pins. The output follows
 * once the second and third stages agree.
 * Assumes pins are static or slow compared with pclk.
 */
module slc_pin_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] pin,
    output logic      [W-1:0] level
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] val;
    } slc_sync_st_t;

    slc_sync_st_t s_q;
    slc_sync_st_t s_d;

    always_comb begin
        s_d    = s_q;
        s_d.s1 = pin;
        s_d.s2 = s_q.s1;
        s_d.s3 = s_q.s2;
        for (int i = 0; i < W; i++) begin
            if (s_q.s2[i] == s_q.s3[i]) begin
                s_d.val[i] = s_q.s3[i];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign level = s_q.val;
endmodule // slc_pin_sync

// ---- hw/slc_timer.sv ----
/*
 * Loadable down counter. Counts on tick, pulses done on the tick that
 * reaches zero. Clear wins over load.
 * Assumes tick is a one-cycle enable on pclk.
 */
module slc_timer #(
    parameter int unsigned W = 8
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         clear,
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    input  wire logic         tick,
    output logic              busy,
    output logic              done
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic         done;
    } slc_tmr_st_t;

    slc_tmr_st_t s_q;
    slc_tmr_st_t s_d;

    always_comb begin
        s_d      = s_q;
        s_d.done = 1'b0;
        if (clear) begin
            s_d.cnt = '0;
        end else if (load) begin
            s_d.cnt = load_val;
        end else if (tick && s_q.cnt != '0) begin
            s_d.cnt  = s_q.cnt - W'(1);
            s_d.done = (s_q.cnt == W'(1));
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign busy = (s_q.cnt != '0);
    assign done = s_q.done;
endmodule // slc_timer

// ---- tb/slc_regs_monitor.sv ----
/*
 * Concurrent checks on the link control register bank ports.
 * Assumes binding into slc_regs and short sim values for the counts.
 */
module slc_regs_monitor
    import slc_pkg::*;
#(
    parameter int unsigned HOLDOFF_CYCLES = HOLDOFF_CYC,
    parameter int unsigned MS_CYCLES      = MS_CYC
) (
    input wire logic         pclk,
    input wire logic         presetn,
    input wire slc_apb_req_t apb_i,
    input wire slc_apb_rsp_t apb_o,
    input wire logic         auto_start_pin,
    input wire logic         control_direction_pin,
    input wire logic         pll_locked,
    input wire slc_ctl_t     ctl_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic acc;
    logic wr_link;
    logic wr_mod;
    logic unmapped;
    logic        serial_prev;
    int unsigned hold_left;

    assign acc      = apb_i.psel & apb_i.penable & apb_o.pready;
    assign unmapped = (apb_i.paddr[11:2] != MODCAL_IDX) && (apb_i.paddr[11:2] != LINKCTL_IDX);
    assign wr_link  = acc & apb_i.pwrite & apb_i.pstrb[0] & (apb_i.paddr[11:2] == LINKCTL_IDX);
    assign wr_mod   = acc & apb_i.pwrite & apb_i.pstrb[0] & (apb_i.paddr[11:2] == MODCAL_IDX);

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Blackout must outlast the longest window a slip could shorten it to
    sequence rev_quiet;
        !ctl_o.reverse_channel_enable [*8];
    endsequence

    // Counts the full blackout from each start or stop of the link
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_prev <= 1'b0;
            hold_left   <= 0;
        end else begin
            serial_prev <= ctl_o.serial_link_enable;
            if (ctl_o.serial_link_enable != serial_prev) begin
                hold_left <= HOLDOFF_CYCLES;
            end else if (hold_left != 0) begin
                hold_left <= hold_left - 1;
            end
        end
    end

    chk_serial_write:
        assert property (wr_link |=> ctl_o.serial_link_enable == $past(apb_i.pwdata[7]))
        else $error("serial enable does not follow write");
    chk_mode_bits:
        assert property (wr_link |=> {ctl_o.config_link_enable, ctl_o.prbs_test_enable, ctl_o.sleep}
                                     == $past(apb_i.pwdata[6:4]))
        else $error("config, prbs or sleep bit does not follow write");
    chk_iftype_decode:
        assert property (wr_link |=> ctl_o.periph_i2c_enable == ($past(apb_i.pwdata[3:2]) == 2'h0)
                                     && ctl_o.periph_uart_enable == ($past(apb_i.pwdata[3:2]) == 2'h1))
        else $error("peripheral type decode wrong");
    chk_fwd_write:
        assert property (wr_link |=> ctl_o.forward_channel_enable == $past(apb_i.pwdata[0]))
        else $error("forward channel enable does not follow write");
    chk_rev_blocked:
        assert property (wr_link && !apb_i.pwdata[1] |=> !ctl_o.reverse_channel_enable)
        else $error("reverse channel open while its bit is clear");
    chk_divider_write:
        assert property (wr_mod |=> ctl_o.sawtooth_divider == $past(apb_i.pwdata[5:0])
                                    && ctl_o.sawtooth_autocal == ($past(apb_i.pwdata[5:0]) == 6'h0))
        else $error("divider or autocal wrong after write");
    chk_link_blackout:
        assert property ($changed(ctl_o.serial_link_enable) |-> rev_quiet)
        else $error("reverse channel open during blackout");
    chk_blackout_hold:
        assert property (hold_left != 0 |-> !ctl_o.reverse_channel_enable)
        else $error("reverse channel open before full blackout ends");
    chk_recal_lock:
        assert property ($rose(pll_locked) |-> ##[1:2] ctl_o.modulation_recal)
        else $error("no recalibration after lock");
    chk_recal_pulse:
        assert property (ctl_o.modulation_recal |=> !ctl_o.modulation_recal)
        else $error("recalibration pulse longer than one cycle");
    chk_unmapped_err:
        assert property (acc && unmapped |-> apb_o.pslverr)
        else $error("no error on unmapped address");
endmodule // slc_regs_monitor

// ---- tb/slc_host_model.sv ----
/*
 * Host controller model: APB master for the register bank.
 * Assumes pready is sampled only at rising edges of pclk.
 */
module slc_host_model
    import slc_pkg::*;
(
    input  wire logic         pclk,
    output slc_apb_req_t      req,
    input  wire slc_apb_rsp_t rsp
);
    timeunit 1ns;
    timeprecision 1ps;

    initial req = '0;

    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                        output logic [31:0] rd, output logic err);
        @(posedge pclk);
        req <= '{psel: 1'h1, penable: 1'h0, pwrite: wr, paddr: a, pwdata: d, pstrb: s};
        @(posedge pclk);
        req.penable <= 1'h1;
        do @(posedge pclk); while (rsp.pready !== 1'h1);
        rd  = rsp.prdata;
        err = rsp.pslverr;
        // Released lines carry inverted values so stale data cannot pass
        req <= '{psel: 1'h0, penable: 1'h0, pwrite: ~wr, paddr: ~a, pwdata: ~d, pstrb: ~s};
    endtask
endmodule // slc_host_model

// ---- tb/tb_top.sv ----
/*
 * Self-checking bench for the link control register bank.
 * Assumes the host model as APB master and short blackout and ms counts.
 */
module tb_top;
    import slc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int unsigned HOLD_T = 20;
    localparam int unsigned MS_T   = 10;

    logic         pclk = 1'h0;
    logic         presetn, as_pin, cd_pin, locked, err;
    slc_apb_req_t req;
    slc_apb_rsp_t rsp;
    slc_ctl_t     ctl;
    logic [31:0]  rd;
    logic [7:0]   link, modc, nl;
    int           bad_count = 0;
    int           total_checks = 0;
    int           n, e;
    int           pm[4] = '{0, 2, 16, 256};

    always #10 pclk = ~pclk;

    slc_host_model host (.pclk(pclk), .req(req), .rsp(rsp));

    slc_regs #(.HOLDOFF_CYCLES(HOLD_T), .MS_CYCLES(MS_T)) dut (
        .pclk(pclk), .presetn(presetn), .apb_i(req), .apb_o(rsp), .auto_start_pin(as_pin),
        .control_direction_pin(cd_pin), .pll_locked(locked), .ctl_o(ctl));

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    function automatic slc_ctl_t exp_ctl(input logic [7:0] l, input logic [7:0] m);
        exp_ctl = '{l[7], l[6], l[5], l[4], l[3:2] == 2'h0, l[3:2] == 2'h1, 1'h0, l[0], m[5:0] == 6'h0, m[5:0], 1'h0};
    endfunction

    // Reverse enable and recal pulse depend on timing, checked apart
    task automatic check_ctl(input logic [7:0] l, input logic [7:0] m);
        slc_ctl_t g;
        g = ctl;
        g.reverse_channel_enable = 1'h0;
        g.modulation_recal = 1'h0;
        check(32'(g), 32'(exp_ctl(l, m)), "ctl");
    endtask

    task automatic put(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        host.xfer(1'h1, a, d, s, rd, err);
    endtask

    task automatic get(input logic [11:0] a);
        host.xfer(1'h0, a, 32'h0, 4'hf, rd, err);
    endtask

    task automatic report_and_stop;
        if (bad_count == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        report_and_stop();
    end

    initial begin
        presetn = 1'h0;
        {as_pin, cd_pin, locked} = 3'h0;
        void'($urandom(60));
        for (int s = 0; s < 4; s++) begin
            @(posedge pclk);
            presetn <= 1'h0;
            {as_pin, cd_pin} <= 2'(s);
            repeat (16) @(posedge pclk);
            presetn <= 1'h1;
            repeat (12) @(posedge pclk);
            link = {~s[1], 2'h0, s[1] & ~s[0], 4'h3};
            get(12'h010); check(rd, {24'h0, link}, "link reset");
            get(12'h00c); check(rd, 32'h0, "modcal reset");
            check_ctl(link, 8'h0);
        end
        modc = 8'h0;
        for (int i = 0; i < 24; i++) begin
            nl = 8'($urandom);
            modc = 8'($urandom);
            if (i < 4) begin
                nl[3:2] = 2'(i);
                modc = (i == 0) ? 8'h0 : {2'(i), modc[5:0]};
            end
            put(12'h00c, {24'($urandom), modc}, 4'h1);
            put(12'h010, {24'($urandom), nl}, 4'h1);
            #1;
            check_ctl(nl, modc);
            if (nl[7] != link[7]) begin
                repeat (HOLD_T) @(posedge pclk);
                #1;
                check(32'(ctl.reverse_channel_enable), 32'h0, "blackout short");
            end
            repeat (4) @(posedge pclk);
            #1;
            check(32'(ctl.reverse_channel_enable), 32'(nl[1]), "rev enable");
            link = nl;
            get(12'h010); check(rd, {24'h0, link}, "link readback");
            get(12'h00c); check(rd, {24'h0, modc}, "modcal readback");
        end
        put(12'h010, {24'h0, ~link}, 4'he);
        get(12'h010); check(rd, {24'h0, link}, "strobe off write");
        for (int a = 0; a < 2; a++) begin
            get(a ? 12'h014 : 12'h000);
            check(rd, 32'h0, "unmapped read data");
            check(32'(err), 32'h1, "unmapped read");
            put(a ? 12'h014 : 12'h000, 32'hff, 4'hf); check(32'(err), 32'h1, "unmapped write");
        end
        for (int c = 0; c < 4; c++) begin
            put(12'h00c, {24'h0, 2'(c), 6'h15}, 4'h1);
            locked <= 1'h1;
            n = 0;
            repeat (600) begin
                @(posedge pclk);
                #1;
                n += int'(ctl.modulation_recal);
            end
            @(posedge pclk);
            locked <= 1'h0;
            repeat (30) @(posedge pclk);
            e = (c == 0) ? 1 : 1 + 600 / (pm[c] * MS_T);
            check(32'(n >= e - (c != 0) && n <= e + (c != 0)), 32'h1, "recal count");
        end
        // Switching to once-only while locked must cancel the pending period
        put(12'h00c, {24'h0, RECAL_2MS, 6'h15}, 4'h1);
        locked <= 1'h1;
        repeat (30) @(posedge pclk);
        put(12'h00c, {24'h0, RECAL_ONCE, 6'h15}, 4'h1);
        n = 0;
        repeat (100) begin
            @(posedge pclk);
            #1;
            n += int'(ctl.modulation_recal);
        end
        @(posedge pclk);
        locked <= 1'h0;
        check(32'(n), 32'h0, "recal after once mode");
        report_and_stop();
    end
endmodule // tb_top

bind slc_regs slc_regs_monitor #(.HOLDOFF_CYCLES(HOLDOFF_CYCLES), .MS_CYCLES(MS_CYCLES)) mon (
    .pclk(pclk), .presetn(presetn), .apb_i(apb_i), .apb_o(apb_o), .auto_start_pin(auto_start_pin),
    .control_direction_pin(control_direction_pin), .pll_locked(pll_locked), .ctl_o(ctl_o));
